// *** hw/lpi_defs.svh ***
`ifndef LPI_DEFS_SVH
`define LPI_DEFS_SVH

// Register offsets on the six-bit microcontroller port address.
`define LPI_ADDR_W          6
`define LPI_DATA_W          8
`define LPI_OFF_MASK_FIRST  6'h13
`define LPI_OFF_MASK_SECOND 6'h14
`define LPI_OFF_STAT_FIRST  6'h18
`define LPI_OFF_STAT_SECOND 6'h19
`define LPI_OFF_GLOBAL_CTRL 6'h20
`define LPI_OFF_CHAN_IND    6'h21

// Field positions in the global interrupt control register.
`define LPI_GC_MASK_BIT     0
`define LPI_GC_POL_HIGH_BIT 1
`define LPI_GC_OPEN_DRN_BIT 2
`define LPI_GC_USED_W       3

// Reset values.
`define LPI_MASK_RST        8'hFF
`define LPI_GCTRL_RST       3'h1
`define LPI_STAT_RST        8'h00
`define LPI_RDATA_UNMAPPED  8'h00

`endif

// *** hw/lpi_pin_ctrl.sv ***
// Contract
// - Edge select pin picks receive clock edge.
// - Rail code 00 single B8ZS/HDB3, 11 slicer.
// - Port acts only while select is low.
// - Loop pins: 00 none, 10 digital, 11 remote.
// - One interrupt output merges enabled sources.
// - Global mask bit and per-source masks.
// - Status and channel indication report causes.
// - Output push-pull either polarity, or open-drain.
`timescale 1ns/1ps
`include "lpi_defs.svh"

module lpi_pin_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] din_i,
  output logic      [W-1:0] dout_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // A change is accepted only once the second and third stages agree.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1     <= RST;
      s2     <= RST;
      s3     <= RST;
      dout_o <= RST;
    end else begin
      s1 <= din_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout_o <= s3;
      end
    end
  end
endmodule

module lpi_pin_ctrl import lpi_pkg::*; (
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire logic           hw_mode_i,
  input  wire logic           rx_clock_edge_select_i,
  input  wire logic           rail_coding_mode_hi_i,
  input  wire logic           rail_coding_mode_lo_i,
  input  wire logic           ch1_loop_select_hi_i,
  input  wire logic           ch1_loop_select_lo_i,
  input  wire lpi_host_port_t host_i,
  input  wire logic [7:0]     irq_event_ch1_i,
  input  wire logic [7:0]     irq_event_ch2_i,
  output lpi_line_cfg_t       line_cfg_o,
  output logic [7:0]          data_o,
  output logic                data_oe_o,
  output logic                irq_o,
  output logic                irq_oe_o
);
  localparam lpi_host_port_t HOST_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                          addr: '0, wdata: '0};

  logic           rst_q1;
  logic           rst_n;
  lpi_host_port_t hp;
  logic           hp_rd_n_q;
  logic           hp_wr_n_q;
  logic [5:0]     pin_raw;
  logic [5:0]     pin_f;
  logic [7:0]     mask_first;
  logic [7:0]     mask_second;
  logic [7:0]     stat_first;
  logic [7:0]     stat_second;
  logic [`LPI_GC_USED_W-1:0] gctrl;
  logic [7:0]     rd_hold;
  logic [5:0]     rd_addr;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  assign pin_raw = {hw_mode_i, rx_clock_edge_select_i, rail_coding_mode_hi_i,
                    rail_coding_mode_lo_i, ch1_loop_select_hi_i, ch1_loop_select_lo_i};

  lpi_pin_sync #(.W(6), .RST(6'h20)) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .din_i   (pin_raw),
    .dout_o  (pin_f)
  );

  lpi_pin_sync #(.W($bits(lpi_host_port_t)), .RST(HOST_IDLE)) u_host_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .din_i   (host_i),
    .dout_o  (hp)
  );

  // Pin configuration decode.
  wire       hw_mode   = pin_f[5];
  wire [1:0] rail_code = pin_f[3:2];
  wire [1:0] loop_code = pin_f[1:0];
  lpi_line_cfg_t next_line_cfg;
  assign next_line_cfg.rx_rising  = ~pin_f[4];
  assign next_line_cfg.code       = lpi_code_t'(rail_code);
  assign next_line_cfg.dual_rail  = rail_code[1];
  assign next_line_cfg.cdr_enable = (rail_code != LPI_CODE_SLICER);
  assign next_line_cfg.loop       = lpi_loop_t'(loop_code);

  // Pins only steer the line while in hardware control mode; otherwise the last setting holds.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_cfg_o <= '0;
    end else if (hw_mode) begin
      line_cfg_o <= next_line_cfg;
    end
  end

  wire port_sel = !hp.cs_n && !hw_mode;
  wire wr_fall  = port_sel && hp_wr_n_q && !hp.wr_n;
  wire rd_fall  = port_sel && hp_rd_n_q && !hp.rd_n;
  wire rd_rise  = !hp_rd_n_q && hp.rd_n;
  wire hit_mask_first  = (hp.addr == `LPI_OFF_MASK_FIRST);
  wire hit_mask_second = (hp.addr == `LPI_OFF_MASK_SECOND);
  wire hit_gctrl       = (hp.addr == `LPI_OFF_GLOBAL_CTRL);

  wire [7:0] pend_first  = stat_first & ~mask_first;
  wire [7:0] pend_second = stat_second & ~mask_second;
  wire [1:0] chan_ind    = {|pend_second, |pend_first};
  wire       irq_active  = (|chan_ind) && !gctrl[`LPI_GC_MASK_BIT];

  wire [7:0] next_rdata;
  assign next_rdata =
      (hp.addr == `LPI_OFF_MASK_FIRST)  ? mask_first  :
      (hp.addr == `LPI_OFF_MASK_SECOND) ? mask_second :
      (hp.addr == `LPI_OFF_STAT_FIRST)  ? stat_first  :
      (hp.addr == `LPI_OFF_STAT_SECOND) ? stat_second :
      (hp.addr == `LPI_OFF_GLOBAL_CTRL) ? {5'h00, gctrl} :
      (hp.addr == `LPI_OFF_CHAN_IND)    ? {6'h00, chan_ind} :
      `LPI_RDATA_UNMAPPED;

  // Status clears only the bits that the host actually saw, so late events survive.
  wire clr_first  = rd_rise && (rd_addr == `LPI_OFF_STAT_FIRST);
  wire clr_second = rd_rise && (rd_addr == `LPI_OFF_STAT_SECOND);
  wire [7:0] next_stat_first  = (stat_first & ~(clr_first ? rd_hold : 8'h00))
                                | irq_event_ch1_i;
  wire [7:0] next_stat_second = (stat_second & ~(clr_second ? rd_hold : 8'h00))
                                | irq_event_ch2_i;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hp_rd_n_q   <= 1'b1;
      hp_wr_n_q   <= 1'b1;
      mask_first  <= `LPI_MASK_RST;
      mask_second <= `LPI_MASK_RST;
      gctrl       <= `LPI_GCTRL_RST;
      rd_hold     <= `LPI_RDATA_UNMAPPED;
      rd_addr     <= '0;
    end else begin
      hp_rd_n_q <= hp.rd_n;
      hp_wr_n_q <= hp.wr_n;
      if (wr_fall && hit_mask_first) begin
        mask_first <= hp.wdata;
      end
      if (wr_fall && hit_mask_second) begin
        mask_second <= hp.wdata;
      end
      if (wr_fall && hit_gctrl) begin
        gctrl <= hp.wdata[`LPI_GC_USED_W-1:0];
      end
      if (rd_fall) begin
        rd_hold <= next_rdata;
        rd_addr <= hp.addr;
      end else if (rd_rise) begin
        rd_addr <= '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_first  <= `LPI_STAT_RST;
      stat_second <= `LPI_STAT_RST;
    end else begin
      stat_first  <= next_stat_first;
      stat_second <= next_stat_second;
    end
  end

  assign data_o = rd_hold;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= port_sel && !hp.rd_n;
    end
  end

  wire open_drn  = gctrl[`LPI_GC_OPEN_DRN_BIT];
  wire pol_high  = gctrl[`LPI_GC_POL_HIGH_BIT];
  wire next_irq  = open_drn ? 1'b0 : (irq_active ~^ pol_high);
  wire next_oe   = open_drn ? irq_active : 1'b1;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o    <= 1'b1;
      irq_oe_o <= 1'b1;
    end else begin
      irq_o    <= next_irq;
      irq_oe_o <= next_oe;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  irq_gmask_a: assert property (
    gctrl[`LPI_GC_MASK_BIT] && !open_drn && pol_high |=> !irq_o)
    else $error("Interrupt asserted while globally masked.");
  irq_merge_a: assert property (
    (|(stat_first & ~mask_first)) && !gctrl[`LPI_GC_MASK_BIT] && !open_drn && pol_high
    |=> irq_o)
    else $error("Enabled pending source did not raise interrupt.");
  irq_od_a: assert property (
    open_drn |=> !irq_o && (irq_oe_o == $past(irq_active)))
    else $error("Open-drain interrupt drives high or wrong enable.");
  irq_low_a: assert property (
    !open_drn && !pol_high |=> irq_oe_o && (irq_o == !$past(irq_active)))
    else $error("Active-low interrupt level wrong.");
  stat_sticky_a: assert property (
    irq_event_ch1_i[0] |=> stat_first[0])
    else $error("Event lost from first status register.");
  port_ignore_a: assert property (
    (hp.cs_n || hw_mode) |=> $stable(mask_first) && $stable(mask_second) && !data_oe_o)
    else $error("Port acted while deselected.");
  rail_slicer_a: assert property (
    hw_mode && rail_code == 2'h3 |=> line_cfg_o.dual_rail && !line_cfg_o.cdr_enable)
    else $error("Slicer code decoded wrongly.");
  rail_cdr_a: assert property (
    hw_mode && rail_code == 2'h2 |=> line_cfg_o.dual_rail && line_cfg_o.cdr_enable)
    else $error("Dual rail code decoded wrongly.");
  rail_ami_a: assert property (
    hw_mode && rail_code == 2'h1 |=> !line_cfg_o.dual_rail && line_cfg_o.code == LPI_CODE_AMI)
    else $error("AMI code decoded wrongly.");
  loop_map_a: assert property (
    hw_mode && loop_code == 2'h2 |=> line_cfg_o.loop == LPI_LOOP_DIGITAL)
    else $error("Digital loopback code decoded wrongly.");
  loop_analog_a: assert property (
    hw_mode && loop_code == 2'h1 |=> line_cfg_o.loop == LPI_LOOP_ANALOG)
    else $error("Analog loopback code decoded wrongly.");
  edge_sel_a: assert property (
    hw_mode |=> line_cfg_o.rx_rising == !$past(pin_f[4]))
    else $error("Receive clock edge selection wrong.");

  cov_mask_write_c: cover property (wr_fall && hit_mask_first);
  cov_stat_clear_c: cover property (clr_first && (|stat_first));
  cov_irq_od_c:     cover property (open_drn && irq_oe_o);
endmodule

// *** hw/lpi_pkg.sv ***
package lpi_pkg;

  // Line coding selected by the rail and coding mode pins.
  typedef enum logic [1:0] {
    LPI_CODE_B8ZS_HDB3 = 2'h0,
    LPI_CODE_AMI       = 2'h1,
    LPI_CODE_DUAL_CDR  = 2'h2,
    LPI_CODE_SLICER    = 2'h3
  } lpi_code_t;

  // Channel 1 loopback; inband loopback has no pin code.
  typedef enum logic [1:0] {
    LPI_LOOP_NONE    = 2'h0,
    LPI_LOOP_ANALOG  = 2'h1,
    LPI_LOOP_DIGITAL = 2'h2,
    LPI_LOOP_REMOTE  = 2'h3
  } lpi_loop_t;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [5:0] addr;
    logic [7:0] wdata;
  } lpi_host_port_t;

  typedef struct packed {
    logic      rx_rising;
    logic      dual_rail;
    logic      cdr_enable;
    lpi_code_t code;
    lpi_loop_t loop;
  } lpi_line_cfg_t;

endpackage

// *** testbench/lineif_pin_control_irq_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end

module lineif_pin_control_irq_tb import lpi_pkg::*;;
  logic           clk_i = 1'b0, rst_n_i = 1'b0, hw_mode = 1'b0, edge_sel = 1'b0;
  logic [1:0]     rail = 2'h0, loop = 2'h0;
  logic [7:0]     ev1 = 8'h00, ev2 = 8'h00, data_o, v;
  logic           data_oe_o, irq_o, irq_oe_o;
  lpi_host_port_t host_port;
  lpi_line_cfg_t  line_cfg_o, exp_cfg;
  int             err_total = 0, checks = 0, seed = 32'hAE5C25A4;
  int             m1 = 255, m2 = 255, gc = 1, s1 = 0, s2 = 0;
  logic [5:0]     probe_addr [7] = '{6'h13, 6'h14, 6'h18, 6'h19, 6'h20, 6'h21, 6'h3F};

  initial forever #5 clk_i = ~clk_i;

  lpi_host_model host (.clk_i(clk_i), .port_o(host_port));

  lpi_pin_ctrl dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hw_mode_i(hw_mode),
    .rx_clock_edge_select_i(edge_sel), .rail_coding_mode_hi_i(rail[1]),
    .rail_coding_mode_lo_i(rail[0]), .ch1_loop_select_hi_i(loop[1]),
    .ch1_loop_select_lo_i(loop[0]), .host_i(host_port), .irq_event_ch1_i(ev1),
    .irq_event_ch2_i(ev2), .line_cfg_o(line_cfg_o), .data_o(data_o),
    .data_oe_o(data_oe_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o)
  );

  function automatic int rv(input logic [5:0] a);
    case (a)
      6'h13: return m1;
      6'h14: return m2;
      6'h18: return s1;
      6'h19: return s2;
      6'h20: return gc;
      6'h21: return {((s2 & ~m2) != 0), ((s1 & ~m1) != 0)};
      default: return 0;
    endcase
  endfunction

  task automatic chk_irq();
    logic act;
    act = !gc[0] && (rv(6'h21) != 0);
    #1;
    if (!gc[2] || act) `CHK(irq_o, gc[2] ? 1'b0 : (gc[1] ? act : !act))
    `CHK(irq_oe_o, gc[2] ? act : 1'b1)
  endtask

  task automatic rd(input logic [5:0] a);
    v = rv(a);
    host.access(a, 8'h00, 1'b1, 1'b0);
    #1;
    `CHK(data_oe_o, 1'b1)
    `CHK(data_o, v)
    host.release_bus();
    `CHK(data_oe_o, 1'b0)
    if (a == 6'h18) s1 = 0;
    if (a == 6'h19) s2 = 0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic sel_n);
    host.access(a, d, 1'b0, sel_n);
    host.release_bus();
    if (!sel_n && a == 6'h13) m1 = d;
    if (!sel_n && a == 6'h14) m2 = d;
    if (!sel_n && a == 6'h20) gc = d[2:0];
  endtask

  task automatic pulse(input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clk_i);
    ev1 <= b1;
    ev2 <= b2;
    @(posedge clk_i);
    ev1 <= 8'h00;
    ev2 <= 8'h00;
    s1 |= b1;
    s2 |= b2;
    repeat (4) @(posedge clk_i);
    chk_irq();
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk_irq();
    for (int i = 0; i < 7; i++) rd(probe_addr[i]);
    wr(6'h13, 8'h0F, 1'b1);
    host.access(6'h13, 8'h00, 1'b1, 1'b1);
    #1;
    `CHK(data_oe_o, 1'b0)
    host.release_bus();
    rd(6'h13);
    $display("test reset and select done");
    hw_mode <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_i);
      {edge_sel, rail, loop} <= i[4:0];
      repeat (10) @(posedge clk_i);
      exp_cfg = '{!edge_sel, rail[1], rail != 2'h3, lpi_code_t'(rail), lpi_loop_t'(loop)};
      #1;
      `CHK(line_cfg_o, exp_cfg)
    end
    @(posedge clk_i);
    hw_mode <= 1'b0;
    $display("test pin modes done");
    wr(6'h20, 8'h00, 1'b0);
    wr(6'h13, 8'hFE, 1'b0);
    pulse(8'h02, 8'h00);
    pulse(8'h01, 8'h00);
    rd(6'h21);
    rd(6'h18);
    chk_irq();
    wr(6'h14, $random(seed), 1'b0);
    pulse(8'h00, $random(seed));
    rd(6'h21);
    rd(6'h19);
    rd(6'h14);
    for (int i = 2; i >= 0; i--) begin
      wr(6'h20, 8'h02 << i[1], 1'b0);
      pulse(8'h01, 8'h00);
      wr(6'h20, 8'h07 >> i[0], 1'b0);
      chk_irq();
      rd(6'h18);
    end
    rd(6'h20);
    $display("test interrupts done");
    wrap_up();
  end
endmodule

// *** testbench/lpi_host_model.sv ***
`timescale 1ns/1ps

module lpi_host_model import lpi_pkg::*; (
  input  wire logic     clk_i,
  output lpi_host_port_t port_o
);
  initial port_o = '{1'b1, 1'b1, 1'b1, 6'h00, 8'h00};

  task automatic access(input logic [5:0] a, input logic [7:0] d, input logic rd,
                        input logic sel_n);
    @(posedge clk_i);
    port_o.cs_n <= sel_n;
    port_o.addr <= a;
    port_o.wdata <= d;
    repeat (6) @(posedge clk_i);
    if (rd) port_o.rd_n <= 1'b0;
    else port_o.wr_n <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // Released lines show the inverse so that a stale value is never mistaken for a good one.
  task automatic release_bus();
    @(posedge clk_i);
    port_o.rd_n <= 1'b1;
    port_o.wr_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    port_o.cs_n <= 1'b1;
    port_o.addr <= ~port_o.addr;
    port_o.wdata <= ~port_o.wdata;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
